/* File: rtl/periodic_timer.v */
`timescale 1ns/1ps
`include "periodic_timer_defs.vh"

// Operation
// - Capture source bit picks capture or clock pin
// - Clear select: A match, else period/overflow
// - Overflow clear only when period value zero
// - Clear select ignored in PWM/capture modes
// - Counter readable as low byte, two high bits
// - Compare A held in two RW registers
// - Period value held in two RW registers
// - Mode 00 is compare match output mode
// - Clear select low raises both match flags
// - Clear select high raises only A flag
// - Compare A zero: no A flag; with A clear, wrap at 3FF
// - Compare pin changes only on A match flag or counter-on rise
// - Pin function: none, low, high, toggle
// - Counter-on rise loads initial pin level
// - Mode 11 is compare mode without pin
// - PWM: period clears, A sets duty, flags
// - PWM period from period value, zero means 1024
// - Duty at or above period gives 100 percent
// - PWM functions 00/01 force inactive/active level
// - Output control and invert set PWM polarity
// - Counter-on rise clears counter, fall holds
// - Pause freezes counter, release resumes
// - Clock source select picks counter clock
module periodic_timer #(
  parameter CNT_W = 10
) (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        capture_input_pin_i,
  input  wire        ext_clock_pin_i,
  input  wire        sub_clk_i,
  output reg         capture_trigger_o,
  output reg         timer_pin_o,
  output reg         timer_pin_oe_o
);

  // Register file and state
  reg [7:0]       ctrl0_r;
  reg [7:0]       ctrl1_r;
  reg [CNT_W-1:0] cmpa_r;
  reg [CNT_W-1:0] per_r;
  reg [CNT_W-1:0] cnt_r;
  reg             flag_a_r;
  reg             flag_p_r;
  reg             out_state_r;
  reg             on_prev_r;
  reg [5:0]       presc_r;

  // Field views
  wire       pause     = ctrl0_r[`CTRL0_PAUSE_BIT];
  wire [2:0] clk_sel   = ctrl0_r[`CTRL0_CLKSEL_MSB:`CTRL0_CLKSEL_LSB];
  wire       cnt_on    = ctrl0_r[`CTRL0_ON_BIT];
  wire [1:0] mode      = ctrl1_r[`CTRL1_MODE_MSB:`CTRL1_MODE_LSB];
  wire [1:0] pin_fn    = ctrl1_r[`CTRL1_PINF_MSB:`CTRL1_PINF_LSB];
  wire       out_ctl   = ctrl1_r[`CTRL1_OC_BIT];
  wire       out_inv   = ctrl1_r[`CTRL1_INV_BIT];
  wire       cap_src   = ctrl1_r[`CTRL1_CAPSRC_BIT];
  wire       clr_sel   = ctrl1_r[`CTRL1_CLRSEL_BIT];

  // Bus phase decode
  wire acc_done  = psel_i & penable_i & pready_o;
  wire acc_first = psel_i & penable_i & ~pready_o;
  wire wr_en     = acc_done & pwrite_i;

  // Address decode, used for the error answer only
  function addr_hit;
    input [11:0] a;
    begin
      addr_hit = (a[1:0] == 2'b00) && (a <= `TMR_FLAGS_OFS);
    end
  endfunction

  // Write strobe for one register offset
  function wr_to;
    input        we;
    input [11:0] a;
    input [11:0] ofs;
    begin
      wr_to = we && (a == ofs);
    end
  endfunction

  // High register view of a 10-bit value: two bits, rest zero
  function [7:0] high_bits;
    input [CNT_W-1:0] v;
    begin
      high_bits = {6'h00, v[9:8]};
    end
  endfunction

  // Index of each pin-borne clock source in the edge history
  localparam SRC_PIN = 0;
  localparam SRC_SUB = 1;

  // Edge history for the pin clock and the sub clock
  wire [1:0] src_lvl = {sub_clk_i, ext_clock_pin_i};
  wire [1:0] src_rise;
  wire [1:0] src_fall;
  genvar     g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_src_edge
      reg prev_r;
      always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          prev_r <= 1'b0;
        end else begin
          prev_r <= src_lvl[g];
        end
      end
      assign src_rise[g] = src_lvl[g] & ~prev_r;
      assign src_fall[g] = ~src_lvl[g] & prev_r;
    end
  endgenerate

  // Counter clock tick from the selected source
  reg tick;
  always @* begin
    case (clk_sel)
      `CLK_SYS_DIV4: tick = (presc_r[1:0] == 2'h3);
      `CLK_SYS:      tick = 1'b1;
      `CLK_H_DIV16:  tick = (presc_r[3:0] == 4'hf);
      `CLK_H_DIV64:  tick = (presc_r == 6'h3f);
      `CLK_SUB_A,
      `CLK_SUB_B:    tick = src_rise[SRC_SUB];
      `CLK_PIN_RISE: tick = src_rise[SRC_PIN];
      `CLK_PIN_FALL: tick = src_fall[SRC_PIN];
      default:       tick = 1'b0;
    endcase
  end

  // Count step: counter runs when on, not paused, on a tick
  wire on_rise = cnt_on & ~on_prev_r;
  wire step    = cnt_on & ~pause & tick & ~on_rise;
  wire [CNT_W:0] inc     = {1'b0, cnt_r} + {{CNT_W{1'b0}}, 1'b1};
  // A zero period compares against 1024, i.e. the overflow
  wire [CNT_W:0] per_eff = {~|per_r, per_r};
  wire per_hit = step && (inc == per_eff);
  wire a_hit   = step && (|cmpa_r) && !inc[CNT_W] &&
                 (inc[CNT_W-1:0] == cmpa_r);

  // Mode dependent clear and flag decisions
  wire cmp_mode = (mode == `MODE_COMPARE) || (mode == `MODE_TIMER);
  wire use_a    = cmp_mode & clr_sel;
  reg  clr_cnt;
  reg  set_a;
  reg  set_p;
  always @* begin
    if (use_a) begin
      clr_cnt = a_hit;
      set_a   = a_hit;
      set_p   = 1'b0;
    end else begin
      clr_cnt = per_hit;
      set_a   = a_hit;
      set_p   = per_hit;
    end
  end

  // Read data mux
  reg [7:0] rd_byte;
  always @* begin
    case (paddr_i)
      `TMR_CTRL0_OFS:   rd_byte = {ctrl0_r[7:3], 3'h0};
      `TMR_CTRL1_OFS:   rd_byte = ctrl1_r;
      `TMR_CNT_LO_OFS:  rd_byte = cnt_r[7:0];
      `TMR_CNT_HI_OFS:  rd_byte = high_bits(cnt_r);
      `TMR_CMPA_LO_OFS: rd_byte = cmpa_r[7:0];
      `TMR_CMPA_HI_OFS: rd_byte = high_bits(cmpa_r);
      `TMR_PER_LO_OFS:  rd_byte = per_r[7:0];
      `TMR_PER_HI_OFS:  rd_byte = high_bits(per_r);
      `TMR_FLAGS_OFS:   rd_byte = {6'h00, flag_p_r, flag_a_r};
      default:          rd_byte = 8'h00;
    endcase
  end

  // Answer data: the read byte, zero for writes
  wire [31:0] prdata_nxt = pwrite_i ? 32'h0000_0000
                                    : {24'h00_0000, rd_byte};

  // APB slave: one wait state, then pready for one cycle
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (acc_first) begin
      pready_o  <= 1'b1;
      prdata_o  <= prdata_nxt;
      pslverr_o <= ~addr_hit(paddr_i);
    end else begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
  end

  // Control and compare registers
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl0_r <= `CTRL0_RST;
      ctrl1_r <= `CTRL1_RST;
      cmpa_r  <= `CMP_RST;
      per_r   <= `CMP_RST;
    end else begin
      if (wr_to(wr_en, paddr_i, `TMR_CTRL0_OFS))
        ctrl0_r <= {pwdata_i[7:3], 3'h0};
      if (wr_to(wr_en, paddr_i, `TMR_CTRL1_OFS))
        ctrl1_r <= pwdata_i[7:0];
      if (wr_to(wr_en, paddr_i, `TMR_CMPA_LO_OFS))
        cmpa_r[7:0] <= pwdata_i[7:0];
      if (wr_to(wr_en, paddr_i, `TMR_CMPA_HI_OFS))
        cmpa_r[9:8] <= pwdata_i[1:0];
      if (wr_to(wr_en, paddr_i, `TMR_PER_LO_OFS))
        per_r[7:0] <= pwdata_i[7:0];
      if (wr_to(wr_en, paddr_i, `TMR_PER_HI_OFS))
        per_r[9:8] <= pwdata_i[1:0];
    end
  end

  // Free-running prescaler and counter-on history
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      presc_r    <= 6'h00;
      on_prev_r  <= 1'b0;
    end else begin
      presc_r    <= presc_r + 6'h01;
      on_prev_r  <= cnt_on;
    end
  end

  // Counter next value: cleared on enable rise, holds when idle
  reg [CNT_W-1:0] cnt_nxt;
  always @* begin
    cnt_nxt = cnt_r;
    if (on_rise) begin
      cnt_nxt = {CNT_W{1'b0}};
    end else if (step) begin
      if (clr_cnt) begin
        cnt_nxt = {CNT_W{1'b0}};
      end else begin
        cnt_nxt = inc[CNT_W-1:0];
      end
    end
  end

  // Counter register
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= {CNT_W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Sticky match flags, write one to clear, set wins
  wire clr_flags = wr_to(wr_en, paddr_i, `TMR_FLAGS_OFS);
  reg  flag_a_nxt;
  reg  flag_p_nxt;
  always @* begin
    flag_a_nxt = flag_a_r;
    flag_p_nxt = flag_p_r;
    if (clr_flags && pwdata_i[`FLAG_MATCH_A_BIT])
      flag_a_nxt = 1'b0;
    if (clr_flags && pwdata_i[`FLAG_PERIOD_BIT])
      flag_p_nxt = 1'b0;
    if (set_a)
      flag_a_nxt = 1'b1;
    if (set_p)
      flag_p_nxt = 1'b1;
  end

  // Flag registers
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end else begin
      flag_a_r <= flag_a_nxt;
      flag_p_r <= flag_p_nxt;
    end
  end

  // Compare mode pin state: initial level, then A match action
  reg out_state_nxt;
  always @* begin
    out_state_nxt = out_state_r;
    if (on_rise) begin
      out_state_nxt = out_ctl;
    end else if (set_a) begin
      case (pin_fn)
        `PINF_LOW:    out_state_nxt = 1'b0;
        `PINF_HIGH:   out_state_nxt = 1'b1;
        `PINF_TOGGLE: out_state_nxt = ~out_state_r;
        default:      out_state_nxt = out_state_r;
      endcase
    end
  end

  // Compare mode pin state register
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_state_r <= 1'b0;
    end else begin
      out_state_r <= out_state_nxt;
    end
  end

  // PWM level: active while count below duty, or always
  wire duty_full  = ({1'b0, cmpa_r} >= per_eff);
  wire pwm_active = duty_full || (cnt_r < cmpa_r);
  reg  pwm_level;
  always @* begin
    case (pin_fn)
      `PINF_NONE: pwm_level = ~out_ctl;
      `PINF_LOW:  pwm_level = out_ctl;
      `PINF_HIGH: pwm_level = pwm_active ? out_ctl : ~out_ctl;
      default:    pwm_level = ~out_ctl;
    endcase
  end

  // Pin level and enable per mode; timer and capture release it
  reg timer_pin_nxt;
  reg timer_pin_oe_nxt;
  always @* begin
    case (mode)
      `MODE_COMPARE: begin
        timer_pin_nxt    = out_state_r ^ out_inv;
        timer_pin_oe_nxt = 1'b1;
      end
      `MODE_PWM: begin
        timer_pin_nxt    = pwm_level ^ out_inv;
        timer_pin_oe_nxt = 1'b1;
      end
      `MODE_TIMER: begin
        timer_pin_nxt    = 1'b0;
        timer_pin_oe_nxt = 1'b0;
      end
      default: begin
        timer_pin_nxt    = 1'b0;
        timer_pin_oe_nxt = 1'b0;
      end
    endcase
  end

  // Output registers: pin, enable and capture trigger
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer_pin_o       <= 1'b0;
      timer_pin_oe_o    <= 1'b0;
      capture_trigger_o <= 1'b0;
    end else begin
      timer_pin_o       <= timer_pin_nxt;
      timer_pin_oe_o    <= timer_pin_oe_nxt;
      capture_trigger_o <= cap_src ? ext_clock_pin_i
                                   : capture_input_pin_i;
    end
  end

endmodule

/* File: rtl/periodic_timer_defs.vh */
`ifndef PERIODIC_TIMER_DEFS_VH
`define PERIODIC_TIMER_DEFS_VH

// Register byte offsets on the APB
`define TMR_CTRL0_OFS        12'h000
`define TMR_CTRL1_OFS        12'h004
`define TMR_CNT_LO_OFS       12'h008
`define TMR_CNT_HI_OFS       12'h00c
`define TMR_CMPA_LO_OFS      12'h010
`define TMR_CMPA_HI_OFS      12'h014
`define TMR_PER_LO_OFS       12'h018
`define TMR_PER_HI_OFS       12'h01c
`define TMR_FLAGS_OFS        12'h020

// Control 0 fields
`define CTRL0_PAUSE_BIT      7
`define CTRL0_CLKSEL_MSB     6
`define CTRL0_CLKSEL_LSB     4
`define CTRL0_ON_BIT         3

// Control 1 fields
`define CTRL1_MODE_MSB       7
`define CTRL1_MODE_LSB       6
`define CTRL1_PINF_MSB       5
`define CTRL1_PINF_LSB       4
`define CTRL1_OC_BIT         3
`define CTRL1_INV_BIT        2
`define CTRL1_CAPSRC_BIT     1
`define CTRL1_CLRSEL_BIT     0

// Flag register fields
`define FLAG_MATCH_A_BIT     0
`define FLAG_PERIOD_BIT      1

// Reset values
`define CTRL0_RST            8'h00
`define CTRL1_RST            8'h00
`define CMP_RST              10'h000

// Operating modes
`define MODE_COMPARE         2'b00
`define MODE_CAPTURE         2'b01
`define MODE_PWM             2'b10
`define MODE_TIMER           2'b11

// Pin functions
`define PINF_NONE            2'b00
`define PINF_LOW             2'b01
`define PINF_HIGH            2'b10
`define PINF_TOGGLE          2'b11

// Counter clock sources
`define CLK_SYS_DIV4         3'b000
`define CLK_SYS              3'b001
`define CLK_H_DIV16          3'b010
`define CLK_H_DIV64          3'b011
`define CLK_SUB_A            3'b100
`define CLK_SUB_B            3'b101
`define CLK_PIN_RISE         3'b110
`define CLK_PIN_FALL         3'b111

`endif

/* File: bench/periodic_timer_asserts.sv */
`timescale 1ns/1ps
module periodic_timer_asserts (
  input logic        clk_i,
  input logic        arst_n_i,
  input logic        psel_i,
  input logic        penable_i,
  input logic        pwrite_i,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic        pready_o,
  input logic        pslverr_o,
  input logic        capture_input_pin_i,
  input logic        ext_clock_pin_i,
  input logic        capture_trigger_o,
  input logic        timer_pin_o,
  input logic        timer_pin_oe_o
);
  logic [7:0] sh [16];
  logic [2:0] age;
  wire  [3:0] ix  = paddr_i[5:2];
  wire        wr  = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  wire        act = sh[1][3] ^ sh[1][2];
  wire  [9:0] ca  = {sh[5][1:0], sh[4]};
  wire  [9:0] pe  = {sh[7][1:0], sh[6]};
  wire        cap_sel = sh[1][1] ? ext_clock_pin_i : capture_input_pin_i;
  wire  [7:0] msk = ix == 4'h0 ? 8'hf8 : (ix[0] && ix > 4'h3) ? 8'h03 : 8'hff;
  // Shadow of every write without slave error, and cycles since the last one
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 16; i++) sh[i] <= 8'h00;
      age <= 3'h0;
    end else begin
      if (wr) sh[ix] <= pwdata_i[7:0];
      age <= wr ? 3'h0 : age + {2'h0, age != 3'h7};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence acc_s;
    psel_i && !penable_i ##1 psel_i && penable_i;
  endsequence
  chk_apb_answer: assert property (acc_s |=> pready_o)
    else $error("ready late");
  chk_bad_addr: assert property (pready_o |->
    pslverr_o == (paddr_i > 12'h020 || paddr_i[1:0] != 2'h0))
    else $error("slverr wrong");
  chk_reg_readback: assert property (
    pready_o && !pwrite_i && !pslverr_o && ix[3:1] != 3'h1 && !ix[3]
    |-> prdata_o == {24'h0, sh[ix] & msk}) else $error("readback");
  chk_cnt_high: assert property (
    pready_o && !pwrite_i && paddr_i == 12'h00c |-> prdata_o[31:2] == 30'h0)
    else $error("count high bits");
  chk_capture_src: assert property ($past(arst_n_i) |->
    capture_trigger_o == $past(cap_sel))
    else $error("capture source");
  chk_pin_release: assert property (
    age == 3'h7 && sh[1][7] == sh[1][6] |-> timer_pin_oe_o == !sh[1][6])
    else $error("pin enable");
  chk_pwm_force: assert property (
    age == 3'h7 && sh[0][3] && sh[1][7:5] == 3'h4
    |-> timer_pin_o == (sh[1][4] ~^ act)) else $error("forced level");
  chk_full_duty: assert property (
    age == 3'h7 && sh[0][3] && sh[1][7:4] == 4'ha && pe != 10'h0 && ca >= pe
    |-> timer_pin_o == act) else $error("full duty");
endmodule

bind periodic_timer periodic_timer_asserts chk_u (.*);

/* File: bench/pin_partner.sv */
`timescale 1ns/1ps
module pin_partner (
  input  logic clk_i,
  input  logic run_i,
  input  logic pin_i,
  input  logic pin_oe_i,
  output logic cap_pin_o,
  output logic ext_clk_o,
  output logic sub_clk_o,
  output logic pin_lvl_o
);
  logic [3:0] div = 4'h0;
  // Pull-up holds the pin high while the timer lets it go
  assign pin_lvl_o = pin_oe_i ? pin_i : 1'b1;
  // Capture pin wanders; the external clock runs only when asked
  always @(posedge clk_i) begin
    div <= div + 4'h1;
    cap_pin_o <= div[2];
    sub_clk_o <= div[3];
    if (run_i && div[1:0] == 2'h3) ext_clk_o <= ~ext_clk_o;
  end
  // Known levels at time zero
  initial begin
    cap_pin_o = 1'b0;
    ext_clk_o = 1'b0;
    sub_clk_o = 1'b0;
  end
endmodule

/* File: bench/periodic_timer_tb.sv */
`timescale 1ns/1ps
module periodic_timer_tb;
  logic        clk_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, run = 1'b0;
  logic        penable_i = 1'b0, pwrite_i = 1'b0, pin_lvl, er;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, cnt;
  logic        pready_o, pslverr_o, capture_input_pin_i, ext_clock_pin_i;
  logic        sub_clk_i, capture_trigger_o, timer_pin_o, timer_pin_oe_o;
  int          errors = 0, check_count = 0, hi;
  periodic_timer dut_u (.*);
  pin_partner pp_u (.clk_i(clk_i), .run_i(run), .pin_i(timer_pin_o),
    .pin_oe_i(timer_pin_oe_o), .cap_pin_o(capture_input_pin_i),
    .ext_clk_o(ext_clock_pin_i), .sub_clk_o(sub_clk_i), .pin_lvl_o(pin_lvl));
  // 10 MHz system clock
  always #50 clk_i = ~clk_i;
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdcnt();
    apb(12'h008, 1'b0, 32'h0);
    cnt = rd;
    apb(12'h00c, 1'b0, 32'h0);
    cnt = cnt | (rd << 8);
  endtask
  task automatic cfg(input logic [7:0] c1, input logic [9:0] a, p);
    apb(12'h000, 1'b1, 32'h0);
    apb(12'h004, 1'b1, {24'h0, c1});
    apb(12'h010, 1'b1, {24'h0, a[7:0]});
    apb(12'h014, 1'b1, {30'h0, a[9:8]});
    apb(12'h018, 1'b1, {24'h0, p[7:0]});
    apb(12'h01c, 1'b1, {30'h0, p[9:8]});
    apb(12'h020, 1'b1, 32'h3);
  endtask
  task automatic go(input int n);
    apb(12'h000, 1'b1, 32'h18);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic t_regs();
    for (int a = 8; a < 36; a += 4) begin
      apb(a[11:0], 1'b0, 32'h0);
      cmp(rd, 32'h0);
      apb(a[11:0], 1'b1, 32'hffff_ffff);
      apb(a[11:0], 1'b0, 32'h0);
      hi = (a & 20) == 16 ? 32'hff : (a & 20) == 20 ? 32'h3 : 32'h0;
      cmp(rd, hi);
    end
    apb(12'h024, 1'b0, 32'h0);
    cmp({31'h0, er}, 32'h1);
    $display("register test done");
  endtask
  task automatic t_ctr();
    logic [31:0] c0;
    cfg(8'h01, 10'h005, 10'h002);
    go(40);
    apb(12'h020, 1'b0, 32'h0);
    cmp(rd, 32'h1);
    rdcnt();
    cmp({31'h0, cnt < 32'h5}, 32'h1);
    cfg(8'h00, 10'h003, 10'h007);
    go(40);
    apb(12'h020, 1'b0, 32'h0);
    cmp(rd, 32'h3);
    for (int i = 0; i < 2; i++) begin
      apb(12'h000, 1'b1, i ? 32'h10 : 32'h98);
      rdcnt();
      c0 = cnt;
      repeat (9) @(posedge clk_i);
      rdcnt();
      cmp(cnt, c0);
    end
    cfg(8'h00, 10'h000, 10'h000);
    go(1100);
    apb(12'h020, 1'b0, 32'h0);
    cmp(rd, 32'h2);
    $display("counter test done");
  endtask
  task automatic t_pin();
    for (int f = 0; f < 5; f++) begin
      cfg(f == 4 ? 8'hc1 : {2'h0, f[1:0], f != 2, 3'h1}, 10'h0c8, 10'h000);
      go(20);
      cmp({31'h0, pin_lvl}, {31'h0, f != 2});
      repeat (200) @(posedge clk_i);
      hi = f == 0 || f == 2 || f == 4;
      cmp({31'h0, pin_lvl}, hi);
    end
    apb(12'h020, 1'b0, 32'h0);
    cmp(rd, 32'h1);
    $display("pin test done");
  endtask
  task automatic t_pwm();
    logic [7:0] c1 [7] = '{8'hab, 8'hac, 8'ha0, 8'ha8, 8'h88, 8'h98, 8'ha8};
    int ex [7] = '{30, 70, 70, 100, 0, 100, 256};
    for (int i = 0; i < 7; i++) begin
      cfg(c1[i], i == 3 ? 10'h00c : i == 6 ? 10'h100 : 10'h003,
          i == 6 ? 10'h000 : 10'h00a);
      go(20);
      hi = 0;
      repeat (i == 6 ? 1024 : 100) begin
        @(posedge clk_i);
        hi += pin_lvl;
      end
      cmp(hi, ex[i]);
      apb(12'h020, 1'b0, 32'h0);
      if (i != 3 && i != 6) cmp(rd, 32'h3);
    end
    $display("pwm test done");
  endtask
  task automatic t_clk();
    int dv [8] = '{4, 1, 16, 64, 16, 16, 8, 8};
    run <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      cfg(8'h00, 10'h000, 10'h000);
      apb(12'h000, 1'b1, {25'h0, s[2:0], 4'h8});
      repeat (640) @(posedge clk_i);
      apb(12'h000, 1'b1, 32'h0);
      rdcnt();
      hi = 640 / dv[s];
      cmp({31'h0, cnt >= hi - 1 && cnt <= 648 / dv[s] + 1}, 32'h1);
    end
    run <= 1'b0;
    $display("clock source test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence after a four-cycle reset
  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_ctr();
    t_pin();
    t_pwm();
    t_clk();
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule
